// *** src/emc_pkg.sv ***
package emc_pkg;
  localparam logic [7:0] EMC_PAGE_ADDR = 8'haa;
  localparam logic [7:0] EMC_CFG_ADDR = 8'hc7;
  localparam logic [7:0] EMC_SFR_PAGE_F = 8'h0f;
  localparam logic [7:0] EMC_PAGE_RESET = 8'h00;
  localparam logic [4:0] EMC_CFG_RESET = 5'h03;
  localparam int EMC_MUX_BIT = 4;
  localparam int EMC_MODE_LSB = 2;
  localparam int EMC_ALE_LSB = 0;
  localparam logic [2:0] EMC_CFG_UNUSED = 3'h0;
  localparam int EMC_ONCHIP_BYTES = 256;
  localparam logic [1:0] EMC_STROBE_CYCLES = 2'h1;

  typedef enum logic [1:0] {
    EMC_MODE_INTERNAL = 2'b00,
    EMC_MODE_SPLIT_NOBANK = 2'b01,
    EMC_MODE_SPLIT_BANK = 2'b10,
    EMC_MODE_EXTERNAL = 2'b11
  } emc_mode_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic addr8;
    logic [15:0] addr;
    logic [7:0] wdata;
  } emc_req_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] addr_oe;
    logic [7:0] data;
    logic [7:0] data_oe;
    logic latch_strobe;
    logic rd_n;
    logic wr_n;
    logic claim;
  } emc_pins_type;
endpackage

// *** src/emc_ale_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module emc_ale_timer
  import emc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [1:0] width_code,
  output logic done
);
  logic [2:0] count_q;

  // Code n gives n+1 cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_q <= 3'h0;
    end else if (load) begin
      count_q <= {1'b0, width_code};
    end else if (count_q != 3'h0) begin
      count_q <= count_q - 3'h1;
    end
  end

  // Done must not look at load: the owner reloads on done, which would close a loop
  assign done = (count_q == 3'h0);
endmodule
`default_nettype wire

// *** src/emc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module emc_top
  import emc_pkg::*;
#(
  parameter int ONCHIP_BYTES = EMC_ONCHIP_BYTES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire emc_req_type req,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic onchip_sel,
  output logic [7:0] onchip_addr,
  input wire logic [7:0] onchip_rdata,
  input wire logic [7:0] pin_data_in,
  output emc_pins_type pins
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALE_HIGH = 3'b001,
    ST_ALE_LOW = 3'b010,
    ST_STROBE = 3'b011,
    ST_FINISH = 3'b100
  } emc_state_type;

  logic [7:0] page_q;
  logic [4:0] cfg_q;
  emc_state_type state_q;
  logic [15:0] addr_q;
  logic addr8_q;
  logic write_q;
  logic [7:0] wdata_q;
  logic [1:0] strobe_q;
  logic timer_load;
  logic timer_done;
  logic [15:0] eff_addr;
  logic offchip;
  emc_mode_type mode;
  logic multiplexed;
  logic drive_high;

  function automatic logic sel_hit(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] want);
    sel_hit = (pg == EMC_SFR_PAGE_F) && (ad == want);
  endfunction

  assign mode = emc_mode_type'(cfg_q[EMC_MODE_LSB +: 2]);
  assign multiplexed = !cfg_q[EMC_MUX_BIT];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_q <= EMC_PAGE_RESET;
    end else if (sfr_wr && sel_hit(sfr_page, sfr_addr, EMC_PAGE_ADDR)) begin
      page_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_q <= EMC_CFG_RESET;
    end else if (sfr_wr && sel_hit(sfr_page, sfr_addr, EMC_CFG_ADDR)) begin
      cfg_q <= sfr_wdata[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sel_hit(sfr_page, sfr_addr, EMC_PAGE_ADDR)) begin
      sfr_rdata <= page_q;
    end else if (sel_hit(sfr_page, sfr_addr, EMC_CFG_ADDR)) begin
      sfr_rdata <= {EMC_CFG_UNUSED, cfg_q};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // 8-bit form takes its high byte from the page register
  assign eff_addr = req.addr8 ? {page_q, req.addr[7:0]} : req.addr;

  always_comb begin
    unique case (mode)
      EMC_MODE_INTERNAL: offchip = 1'b0;
      EMC_MODE_SPLIT_NOBANK,
      EMC_MODE_SPLIT_BANK: offchip = (32'(eff_addr) >= ONCHIP_BYTES);
      EMC_MODE_EXTERNAL: offchip = 1'b1;
    endcase
  end

  // High lines stay with the port latches in these cases
  assign drive_high = !(addr8_q && (mode == EMC_MODE_SPLIT_NOBANK || mode == EMC_MODE_EXTERNAL));

  assign timer_load = (state_q == ST_IDLE && req.valid && offchip && multiplexed) ||
                      (state_q == ST_ALE_HIGH && timer_done);

  emc_ale_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .load(timer_load),
    .width_code(cfg_q[EMC_ALE_LSB +: 2]),
    .done(timer_done)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      addr_q <= 16'h0000;
      addr8_q <= 1'b0;
      write_q <= 1'b0;
      wdata_q <= 8'h00;
      strobe_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // On-chip reads need the direction as well, not only off-chip moves
          if (req.valid) begin
            write_q <= req.write;
          end
          if (req.valid && offchip) begin
            addr_q <= eff_addr;
            addr8_q <= req.addr8;
            wdata_q <= req.wdata;
            strobe_q <= EMC_STROBE_CYCLES;
            // Separate pins skip the latch phases entirely
            state_q <= multiplexed ? ST_ALE_HIGH : ST_STROBE;
          end
        end
        ST_ALE_HIGH: begin
          if (timer_done) begin
            state_q <= ST_ALE_LOW;
          end
        end
        ST_ALE_LOW: begin
          if (timer_done) begin
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          strobe_q <= strobe_q - 2'h1;
          if (strobe_q == 2'h1) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      onchip_sel <= 1'b0;
      onchip_addr <= 8'h00;
    end else begin
      // Only the low byte decodes, so higher addresses alias
      onchip_sel <= (state_q == ST_IDLE) && req.valid && !offchip;
      onchip_addr <= eff_addr[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      busy <= (state_q != ST_IDLE) && (state_q != ST_FINISH) ||
              (state_q == ST_IDLE && req.valid && offchip);
      // Done comes with the release of the strobe, as the bus cycle ends
      done <= onchip_sel || (state_q == ST_FINISH);
      if (onchip_sel && !write_q) begin
        rdata <= onchip_rdata;
      end else if (state_q == ST_FINISH && !write_q) begin
        // The registered read strobe is still low here, so the pins carry data
        rdata <= pin_data_in;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins <= '{addr: 16'h0000, addr_oe: 16'h0000, data: 8'h00, data_oe: 8'h00,
                latch_strobe: 1'b0, rd_n: 1'b1, wr_n: 1'b1, claim: 1'b0};
    end else begin
      pins.claim <= (state_q != ST_IDLE) && (state_q != ST_FINISH);
      pins.addr <= addr_q;
      pins.addr_oe[15:8] <= {8{(state_q != ST_IDLE) && (state_q != ST_FINISH) && drive_high}};
      pins.addr_oe[7:0] <= {8{(state_q != ST_IDLE) && (state_q != ST_FINISH) && !(multiplexed
                            && state_q == ST_STROBE)}};
      pins.latch_strobe <= (state_q == ST_ALE_HIGH);
      pins.rd_n <= !(state_q == ST_STROBE && !write_q);
      pins.wr_n <= !(state_q == ST_STROBE && write_q);
      pins.data <= wdata_q;
      pins.data_oe <= {8{state_q == ST_STROBE && write_q}};
    end
  end
endmodule
`default_nettype wire

// *** verif/emc_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module emc_checker
  import emc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic busy,
  input wire logic done,
  input wire logic onchip_sel,
  input wire emc_pins_type pins
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_addr; pins.latch_strobe && pins.addr_oe[7:0] == 8'hff; endsequence
  property p_cfg; $past(sfr_addr) == 8'hc7 && $past(sfr_page) == 8'h0f |-> sfr_rdata[7:5] == 3'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("config spare bits read nonzero");
  property p_idle; pins.claim |-> busy; endproperty
  a_idle: assert property (p_idle) else $error("pins claimed while idle");
  property p_oe; pins.addr_oe != 16'h0000 || pins.data_oe != 8'h00 |-> pins.claim; endproperty
  a_oe: assert property (p_oe) else $error("pins driven without claim");
  property p_ale; $rose(pins.latch_strobe) |-> s_addr; endproperty
  a_ale: assert property (p_ale) else $error("strobe without low address");
  property p_rdwr; !pins.rd_n || !pins.wr_n |-> !pins.latch_strobe; endproperty
  a_rdwr: assert property (p_rdwr) else $error("strobe high in data phase");
  property p_rdoe; !pins.rd_n |-> pins.data_oe == 8'h00; endproperty
  a_rdoe: assert property (p_rdoe) else $error("data driven during read");
  property p_sel; onchip_sel |-> !pins.claim; endproperty
  a_sel: assert property (p_sel) else $error("on-chip access claimed pins");
  property p_rel; $fell(pins.claim) |-> done; endproperty
  a_rel: assert property (p_rel) else $error("pins released before done");
endmodule
bind emc_top emc_checker emc_checker_inst (.clock(clock), .rst_n(rst_n), .sfr_page(sfr_page),
  .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .busy(busy), .done(done), .onchip_sel(onchip_sel), .pins(pins));
`default_nettype wire

// *** verif/emc_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module emc_mem_model
  import emc_pkg::*;
(
  input wire logic clock,
  input wire emc_pins_type pins,
  output logic [7:0] pin_data_in
);
  logic [7:0] mem [256];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [7:0] a;
  // Shared pins carry data later, so the low byte must come from the latch
  assign a = pins.addr_oe[0] ? pins.addr[7:0] : lat_q;
  // Released bus shows the inverse of the last value, not a stale copy
  assign pin_data_in = !pins.rd_n ? mem[a] : ~last_q;
  always_ff @(posedge clock) begin
    if (pins.latch_strobe) lat_q <= pins.addr[7:0];
    if (!pins.wr_n) mem[a] <= pins.data;
    last_q <= pin_data_in;
  end
endmodule
`default_nettype wire

// *** verif/emc_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module emc_top_tb
  import emc_pkg::*;
;
  logic clock, rst_n, sfr_wr, busy, done, onchip_sel;
  logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata, rdata, onchip_addr, onchip_rdata, pin_data_in, pg, cfg;
  logic [7:0] shadow [256];
  emc_req_type req;
  emc_pins_type pins;
  int err_count = 0, checks_done = 0, k, j;
  logic [31:0] rs = 32'h182b;
  emc_top emc_top_inst (.clock(clock), .rst_n(rst_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .req(req), .busy(busy), .done(done), .rdata(rdata),
    .onchip_sel(onchip_sel), .onchip_addr(onchip_addr), .onchip_rdata(onchip_rdata), .pin_data_in(pin_data_in),
    .pins(pins));
  emc_mem_model emc_mem_model_inst (.clock(clock), .pins(pins), .pin_data_in(pin_data_in));
  assign onchip_rdata = onchip_addr ^ 8'h5a;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic off(logic [1:0] m, logic [15:0] e);
    return m == 2'b11 || (m != 2'b00 && e >= 16'h0100);
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic sfr_w(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {sfr_page, sfr_addr, sfr_wdata, sfr_wr} <= {p, a, d, 1'b1};
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clock);
    {sfr_page, sfr_addr} <= {8'h0f, a};
    repeat (2) @(posedge clock);
    #1 chk("sfr_rdata", ex, sfr_rdata);
  endtask
  task automatic acc(input logic w, input logic a8, input logic [15:0] ad, input logic [7:0] wd);
    int n, ls;
    logic sel, clm;
    logic [7:0] oa, hu, ha;
    logic [15:0] e;
    e = a8 ? {pg, ad[7:0]} : ad;
    {sel, clm, ls} = '0;
    @(posedge clock);
    req <= '{1'b1, w, a8, ad, wd};
    @(posedge clock);
    req.valid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (onchip_sel === 1'b1) {sel, oa} = {1'b1, onchip_addr};
      if (pins.claim === 1'b1) {clm, hu, ha} = {1'b1, pins.addr_oe[15:8], pins.addr[15:8]};
      ls += int'(pins.latch_strobe === 1'b1);
      if (done === 1'b1) break;
      @(posedge clock);
    end
    if (n == 40) begin
      err_count++;
      end_of_test();
    end
    chk("offchip", off(cfg[3:2], e), clm);
    chk("onchip", !off(cfg[3:2], e), sel);
    if (!off(cfg[3:2], e)) chk("onchip_addr", e[7:0], oa);
    else if (a8 && cfg[3:2] != 2'b10) chk("high_oe", 8'h00, hu);
    else chk("high_addr", {8'hff, e[15:8]}, {hu, ha});
    if (off(cfg[3:2], e)) chk("strobe_len", cfg[4] ? 0 : cfg[1:0] + 1, ls);
    if (w && off(cfg[3:2], e)) shadow[e[7:0]] = wd;
    if (!w) chk("rdata", off(cfg[3:2], e) ? shadow[e[7:0]] : e[7:0] ^ 8'h5a, rdata);
  endtask
  initial begin
    {rst_n, sfr_wr, sfr_page, sfr_addr, sfr_wdata, req} = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    sfr_r(8'haa, EMC_PAGE_RESET);
    sfr_r(8'hc7, 8'h03);
    sfr_w(8'h00, 8'hc7, 8'hff);
    sfr_r(8'hc7, 8'h03);
    sfr_r(8'h55, 8'h00);
    for (k = 0; k < 8; k++) begin
      cfg = 8'(rnd());
      cfg[4:2] = k[2:0];
      pg = (k[1:0] == 2'b01) ? 8'(rnd() | 32'h1) : 8'(rnd());
      sfr_w(8'h0f, 8'hc7, cfg);
      sfr_w(8'h0f, 8'haa, pg);
      sfr_r(8'hc7, {3'h0, cfg[4:0]});
      sfr_r(8'haa, pg);
      for (j = 0; j < 4; j++) begin
        rs = rnd();
        acc(1'b1, rs[0], j == 0 ? 16'h00ff : j == 1 ? 16'h0100 : rs[31:16], rs[15:8]);
        acc(1'b0, rs[0], j == 0 ? 16'h00ff : j == 1 ? 16'h0100 : rs[31:16], 8'h00);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
